/* File: bench/pmc_chk.sv */
`timescale 1ns/100ps
module pmc_chk #(
    parameter int PAD_W = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // block inputs
    input pmc_pkg::pmc_link_t link_i,
    input wire logic deep_sleep_enable_pin_i,
    input wire logic contact_rst_n_i,
    input wire logic contact_if_en_i,
    input wire logic [PAD_W-1:0] pad_core_i,
    // block outputs
    input pmc_pkg::pmc_ctrl_t ctrl_o,
    input pmc_pkg::pmc_mode_t mode_o,
    input wire logic core_rst_n_o,
    input wire logic [PAD_W-1:0] pad_o,
    input wire logic switched_supply_out_o
);
    import pmc_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    logic con_w;
    logic ena;
    assign con_w = contact_if_en_i && !contact_rst_n_i;
    assign ena = deep_sleep_enable_pin_i;
    pd_entry_a: assert property (link_i.session_end && mode_o == PMC_RUN && ena
        |=> mode_o == PMC_PD) else $error("no power-down");
    pd_gate_a: assert property (mode_o == PMC_PD
        |-> !ctrl_o.clk_en && !ctrl_o.cpu_run && ctrl_o.ret_hold) else $error("pd gating");
    pad_hold_a: assert property (mode_o == PMC_PD |-> pad_o ==
        ($past(mode_o) == PMC_PD ? $past(pad_o) : $past(pad_core_i))) else $error("pad moved");
    sda_wake_a: assert property (mode_o == PMC_PD && $fell(link_i.sda) && !con_w && ena
        |=> mode_o == PMC_RUN && core_rst_n_o && ctrl_o.cpu_run) else $error("sda wake");
    con_wake_a: assert property (mode_o == PMC_PD && con_w && ena
        |=> mode_o == PMC_IDLE && !ctrl_o.cpu_run) else $error("contact wake");
    con_ign_a: assert property (mode_o == PMC_PD && !contact_if_en_i && link_i.sda && ena
        |=> mode_o == PMC_PD) else $error("contact not ignored");
    dpd_in_a: assert property (!ena |=> mode_o == PMC_DPD) else $error("no deep pd");
    dpd_pwr_a: assert property (mode_o == PMC_DPD |-> !ctrl_o.logic_pwr && ctrl_o.i2c_pwr
        && !switched_supply_out_o && !core_rst_n_o) else $error("deep pd power");
    dpd_out_a: assert property (mode_o == PMC_DPD && ena
        |=> mode_o == PMC_BOOT && !core_rst_n_o && ctrl_o.logic_pwr) else $error("deep pd exit");
    cover property (mode_o == PMC_PD ##1 mode_o == PMC_RUN);
    cover property (mode_o == PMC_PD ##1 mode_o == PMC_IDLE);
    cover property (mode_o == PMC_DPD ##1 mode_o == PMC_BOOT);
endmodule
bind pmc_top pmc_chk #(.PAD_W(PAD_W)) u_pmc_chk (.clk_i, .nrst_i, .link_i, .deep_sleep_enable_pin_i,
    .contact_rst_n_i, .contact_if_en_i, .pad_core_i, .ctrl_o, .mode_o, .core_rst_n_o, .pad_o,
    .switched_supply_out_o);

/* File: bench/pmc_host.sv */
`timescale 1ns/100ps
module pmc_host (
    // clock
    input wire logic clk_i,
    // toward the device
    output pmc_pkg::pmc_link_t link_o,
    output logic deep_sleep_enable_pin_o
);
    import pmc_pkg::*;
    // data line released: pulled up
    initial begin
        link_o = '{session_end: 1'b0, sda: PMC_SDA_IDLE};
        deep_sleep_enable_pin_o = 1'b1;
    end
    task automatic end_session();
        @(posedge clk_i) link_o.session_end <= 1'b1;
        @(posedge clk_i) link_o.session_end <= 1'b0;
    endtask
    task automatic wake(input int slow);
        @(posedge clk_i) link_o.sda <= 1'b0;
        repeat (1 + slow) @(posedge clk_i);
        link_o.sda <= PMC_SDA_IDLE;
    endtask
    task automatic deep(input logic lvl);
        @(posedge clk_i) deep_sleep_enable_pin_o <= lvl;
    endtask
endmodule

/* File: bench/tb_top.sv */
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
    $display("Error %s exp %0h got %0h", n, e, g); end end
module tb_top;
    import pmc_pkg::*;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic contact_rst_n_i = 1'b1;
    logic contact_if_en_i = 1'b0;
    logic [7:0] pad_core_i = 8'h00;
    logic deep_sleep_enable_pin_i;
    logic core_rst_n_o;
    logic switched_supply_out_o;
    logic [7:0] pad_o;
    pmc_link_t link_i;
    pmc_ctrl_t ctrl_o;
    pmc_mode_t mode_o;
    int err_total = 0;
    int total_checks = 0;
    always #5 clk_i = ~clk_i;
    pmc_host u_pmc_host (.clk_i, .link_o(link_i), .deep_sleep_enable_pin_o(deep_sleep_enable_pin_i));
    // short boot keeps the run brief
    pmc_top #(.BOOT_CYCLES(2)) u_pmc_top (.clk_i, .nrst_i, .link_i, .deep_sleep_enable_pin_i, .contact_rst_n_i,
        .contact_if_en_i, .pad_core_i, .ctrl_o, .mode_o, .core_rst_n_o, .pad_o, .switched_supply_out_o);
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic run_up();
        for (int i = 0; i < 40 && mode_o !== PMC_RUN; i++) tick(1);
        `CHK("mode", PMC_RUN, mode_o)
        `CHK("core_rst_n", 1'b1, core_rst_n_o)
    endtask
    task automatic t_pd();
        @(posedge clk_i) pad_core_i <= 8'h5a;
        u_pmc_host.end_session();
        pad_core_i <= 8'ha5;
        tick(2);
        `CHK("mode", PMC_PD, mode_o)
        `CHK("pad", 8'h5a, pad_o)
        `CHK("clk_en", 1'b0, ctrl_o.clk_en)
        `CHK("cpu_run", 1'b0, ctrl_o.cpu_run)
        `CHK("ret_hold", 1'b1, ctrl_o.ret_hold)
        `CHK("pad_hold", 1'b1, ctrl_o.pad_hold)
        u_pmc_host.wake(3);
        tick(1);
        `CHK("mode", PMC_RUN, mode_o)
        `CHK("core_rst_n", 1'b1, core_rst_n_o)
        `CHK("cpu_run", 1'b1, ctrl_o.cpu_run)
        `CHK("pad", 8'ha5, pad_o)
    endtask
    task automatic t_con();
        u_pmc_host.end_session();
        contact_rst_n_i <= 1'b0;
        tick(3);
        `CHK("mode", PMC_PD, mode_o)
        @(posedge clk_i) contact_if_en_i <= 1'b1;
        tick(2);
        `CHK("mode", PMC_IDLE, mode_o)
        `CHK("cpu_run", 1'b0, ctrl_o.cpu_run)
        @(posedge clk_i) contact_rst_n_i <= 1'b1;
        contact_if_en_i <= 1'b0;
        u_pmc_host.end_session();
        u_pmc_host.wake(0);
        tick(1);
        `CHK("mode", PMC_RUN, mode_o)
    endtask
    task automatic t_dpd();
        u_pmc_host.end_session();
        u_pmc_host.deep(1'b0);
        tick(2);
        `CHK("mode", PMC_DPD, mode_o)
        `CHK("supply", 1'b0, switched_supply_out_o)
        `CHK("i2c_pwr", 1'b1, ctrl_o.i2c_pwr)
        `CHK("supply_out", 1'b0, ctrl_o.supply_out)
        `CHK("logic_pwr", 1'b0, ctrl_o.logic_pwr)
        u_pmc_host.deep(1'b1);
        tick(1);
        `CHK("mode", PMC_BOOT, mode_o)
        `CHK("core_rst_n", 1'b0, core_rst_n_o)
        `CHK("supply", 1'b1, switched_supply_out_o)
        run_up();
    endtask
    task automatic give_verdict();
        if (err_total == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #20us;
        err_total++;
        give_verdict();
    end
    initial begin
        repeat (4) @(posedge clk_i);
        nrst_i <= 1'b1;
        run_up();
        t_pd();
        t_con();
        t_dpd();
        give_verdict();
    end
endmodule

/* File: rtl/pmc_edge.sv */
`timescale 1ns/100ps
// falling-edge detector on a synchronous level
module pmc_edge (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // level in, pulse out
    input wire logic lvl_i,
    output logic fall_o
);
    import pmc_pkg::*;

    logic prev;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prev <= PMC_SDA_IDLE;
        end else begin
            prev <= lvl_i;
        end
    end

    assign fall_o = prev & ~lvl_i;
endmodule

/* File: rtl/pmc_pkg.sv */
package pmc_pkg;

    // power modes of the secure element core
    typedef enum logic [2:0] {
        PMC_BOOT,
        PMC_RUN,
        PMC_IDLE,
        PMC_PD,
        PMC_DPD
    } pmc_mode_t;

    // host-link events that the protocol engine hands over
    typedef struct packed {
        logic session_end;
        logic sda;
    } pmc_link_t;

    // gating and supply controls toward the core
    typedef struct packed {
        logic clk_en;
        logic cpu_run;
        logic ret_hold;
        logic pad_hold;
        logic logic_pwr;
        logic supply_out;
        logic i2c_pwr;
    } pmc_ctrl_t;

    localparam int PMC_BOOT_CYCLES = 16;
    localparam int PMC_PAD_W = 8;
    localparam logic [7:0] PMC_PAD_RST = 8'h00;
    localparam logic PMC_SDA_IDLE = 1'b1;

endpackage

/* File: rtl/pmc_top.sv */
`timescale 1ns/100ps
// Notes on behaviour
// - a session-end request from the host puts the device into retentive power-down
// - in power-down all core clocks are gated and the processor halts
// - processor registers and RAM keep their contents through power-down
// - on entering power-down each output pad holds its current level
// - a falling edge on the target data line ends power-down
// - with contact interface on, contact reset ends power-down into idle
// - deep-sleep enable pin low enters deep power-down
// - deep power-down removes logic power and the switched supply; I2C pads stay
// - deep power-down keeps no state; volatile contents are lost
// - deep-sleep enable pin high leaves deep power-down
// - contact reset is ignored unless the contact interface is enabled
module pmc_top #(
    parameter int PAD_W = pmc_pkg::PMC_PAD_W,
    parameter int BOOT_CYCLES = pmc_pkg::PMC_BOOT_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // host link and pins
    input pmc_pkg::pmc_link_t link_i,
    input wire logic deep_sleep_enable_pin_i,
    input wire logic contact_rst_n_i,
    input wire logic contact_if_en_i,
    // pad levels from the core
    input wire logic [PAD_W-1:0] pad_core_i,
    // controls and status
    output pmc_pkg::pmc_ctrl_t ctrl_o,
    output pmc_pkg::pmc_mode_t mode_o,
    output logic core_rst_n_o,
    output logic [PAD_W-1:0] pad_o,
    output logic switched_supply_out_o
);
    import pmc_pkg::*;

    // wide enough to hold BOOT_CYCLES - 1 for any BOOT_CYCLES
    localparam int CW = $clog2(BOOT_CYCLES + 1);

    pmc_mode_t mode;
    pmc_mode_t next_mode;
    logic [CW-1:0] boot_cnt;
    logic [PAD_W-1:0] pad_latch;
    logic sda_fall;
    logic contact_wake;
    logic clk_on;
    logic cpu_on;
    logic ret_on;
    logic pad_freeze;
    logic core_pwr;
    logic supply_on;
    logic pads_pwr;

    // -----------------------------------------------------------------
    // wake detection
    // -----------------------------------------------------------------
    // the edge detector runs on the free clock, not the gated core clock,
    // otherwise a frozen core could never see its own wake edge
    pmc_edge u_sda_edge (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .lvl_i(link_i.sda),
        .fall_o(sda_fall)
    );

    // with only the host link in use the contact reset pin has no effect
    assign contact_wake = contact_if_en_i & ~contact_rst_n_i;

    // -----------------------------------------------------------------
    // mode sequencing
    // -----------------------------------------------------------------
    // the deep-sleep pin overrides every mode, a boot in progress too,
    // because the core supply is about to go away
    always_comb begin
        next_mode = mode;
        if (!deep_sleep_enable_pin_i) begin
            next_mode = PMC_DPD;
        end else begin
            unique case (mode)
                PMC_DPD: begin
                    // pin back high: power returns and the core boots from cold
                    next_mode = PMC_BOOT;
                end
                PMC_BOOT: begin
                    if (boot_cnt == CW'(BOOT_CYCLES - 1)) begin
                        next_mode = PMC_RUN;
                    end
                end
                PMC_RUN, PMC_IDLE: begin
                    if (link_i.session_end) begin
                        next_mode = PMC_PD;
                    end
                end
                PMC_PD: begin
                    // contact reset wins when both wake sources arrive together
                    if (contact_wake) begin
                        next_mode = PMC_IDLE;
                    end else if (sda_fall) begin
                        next_mode = PMC_RUN;
                    end
                end
            endcase
        end
    end

    // mode_o below mirrors this register
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mode <= PMC_BOOT;
        end else begin
            mode <= next_mode;
        end
    end

    // boot counter restarts every time the supply comes back
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            boot_cnt <= '0;
        end else if (mode != PMC_BOOT) begin
            boot_cnt <= '0;
        end else if (boot_cnt != CW'(BOOT_CYCLES - 1)) begin
            boot_cnt <= boot_cnt + CW'(1);
        end
    end

    // -----------------------------------------------------------------
    // pad hold
    // -----------------------------------------------------------------
    // the latch follows the core while awake and freezes on entry
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pad_latch <= PAD_W'(PMC_PAD_RST);
        end else if (mode != PMC_PD && next_mode == PMC_PD) begin
            pad_latch <= pad_core_i;
        end else if (mode != PMC_PD) begin
            pad_latch <= pad_core_i;
        end
    end

    // pad_o is registered, so the held level is the one driven in the last
    // awake cycle and cannot glitch at the entry edge
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pad_o <= PAD_W'(PMC_PAD_RST);
        end else if (next_mode == PMC_PD) begin
            pad_o <= (mode == PMC_PD) ? pad_latch : pad_core_i;
        end else begin
            pad_o <= pad_core_i;
        end
    end

    // -----------------------------------------------------------------
    // core controls
    // -----------------------------------------------------------------
    // every control but i2c_pwr (tied high) is registered from next_mode, so all of them move on the
    // same edge as mode_o and the core never sees a half-changed mode
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mode_o <= PMC_BOOT;
        end else begin
            mode_o <= next_mode;
        end
    end

    // idle keeps its clocks running; only the two power-down modes stop them
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            clk_on <= 1'b0;
            cpu_on <= 1'b0;
        end else begin
            clk_on <= (next_mode != PMC_PD) && (next_mode != PMC_DPD);
            cpu_on <= (next_mode == PMC_RUN);
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ret_on <= 1'b0;
            pad_freeze <= 1'b0;
        end else begin
            ret_on <= (next_mode == PMC_PD);
            pad_freeze <= (next_mode == PMC_PD);
        end
    end

    // the host-side pads stay supplied in every mode, otherwise neither the
    // wake edge nor the deep-sleep pin could be seen
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            core_pwr <= 1'b0;
            supply_on <= 1'b0;
            pads_pwr <= 1'b0;
        end else begin
            core_pwr <= (next_mode != PMC_DPD);
            supply_on <= (next_mode != PMC_DPD);
            pads_pwr <= 1'b1;
        end
    end

    // core held in reset through deep sleep and boot; state is gone
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            core_rst_n_o <= 1'b0;
        end else begin
            core_rst_n_o <= (next_mode != PMC_DPD) && (next_mode != PMC_BOOT);
        end
    end

    // plain wiring: every field below already comes from a flop
    assign switched_supply_out_o = supply_on;

    assign ctrl_o = '{
        clk_en: clk_on,
        cpu_run: cpu_on,
        ret_hold: ret_on,
        pad_hold: pad_freeze,
        logic_pwr: core_pwr,
        supply_out: supply_on,
        i2c_pwr: pads_pwr
    };
endmodule
